// ---- inc/frt_pkg.sv ----
// constants and types shared by the free running timer files
package frt_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] FRT_OFF_COUNTER   = 8'h00;
    localparam logic [7:0] FRT_OFF_COMPARE_A = 8'h04;
    localparam logic [7:0] FRT_OFF_COMPARE_B = 8'h08;
    localparam logic [7:0] FRT_OFF_CAPTURE_A = 8'h0C;
    localparam logic [7:0] FRT_OFF_CAPTURE_B = 8'h10;
    localparam logic [7:0] FRT_OFF_CAPTURE_C = 8'h14;
    localparam logic [7:0] FRT_OFF_CAPTURE_D = 8'h18;
    localparam logic [7:0] FRT_OFF_STATUS    = 8'h1C;
    localparam logic [7:0] FRT_OFF_CONTROL   = 8'h20;
    localparam logic [7:0] FRT_OFF_IRQ_MASK  = 8'h24;
    localparam logic [7:0] FRT_OFF_IRQ_STAT  = 8'h28;

    // ==========================================================
    // status register fields
    localparam int FRT_ST_CAP_A   = 7;
    localparam int FRT_ST_CAP_B   = 6;
    localparam int FRT_ST_CAP_C   = 5;
    localparam int FRT_ST_CAP_D   = 4;
    localparam int FRT_ST_MATCH_A = 3;
    localparam int FRT_ST_MATCH_B = 2;
    localparam int FRT_ST_WRAP    = 1;
    localparam int FRT_ST_CLR_A   = 0;

    // ==========================================================
    // timer control fields
    localparam int FRT_TC_EDGE_HI = 7;
    localparam int FRT_TC_EDGE_LO = 4;
    localparam int FRT_TC_BUF_A   = 3;
    localparam int FRT_TC_BUF_B   = 2;
    localparam int FRT_TC_CLK_HI  = 1;
    localparam int FRT_TC_CLK_LO  = 0;

    // ==========================================================
    // reset values and counter constants
    localparam logic [15:0] FRT_CNT_RESET  = 16'h0000;
    localparam logic [15:0] FRT_CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] FRT_CMP_RESET  = 16'hFFFF;
    localparam logic [7:0]  FRT_CTRL_RESET = 8'h00;
    localparam logic [7:0]  FRT_FLAG_RESET = 8'h00;
    localparam logic [4:0]  FRT_PRE_RESET  = 5'h00;
    localparam logic [4:0]  FRT_DIV2_MASK  = 5'h01;
    localparam logic [4:0]  FRT_DIV8_MASK  = 5'h07;
    localparam logic [4:0]  FRT_DIV32_MASK = 5'h1F;
    localparam logic [31:0] FRT_RD_ZERO    = 32'h0000_0000;

    // counter clock source codes
    typedef enum logic [1:0] {
        FRT_CLK_DIV2  = 2'b00,
        FRT_CLK_DIV8  = 2'b01,
        FRT_CLK_DIV32 = 2'b10,
        FRT_CLK_EXT   = 2'b11
    } frt_clk_src_t;

endpackage

// ---- inc/frt_edge_if.sv ----
// timer core to edge detector signals
interface frt_edge_if;
    logic [3:0] cap_pin;
    logic [3:0] edge_sel;
    logic       ext_pin;
    logic [3:0] cap_evt;
    logic       ext_rise;

    modport detect (input cap_pin, input edge_sel, input ext_pin, output cap_evt, output ext_rise);
    modport core   (output cap_pin, output edge_sel, output ext_pin, input cap_evt, input ext_rise);
endinterface

// ---- hw/frt_edge_detect.sv ----
// edge detector for the capture inputs and the external count clock
module frt_edge_detect
    import frt_pkg::*;
(
    input  wire logic    hclk,
    input  wire logic    hresetn,
    frt_edge_if.detect   eif
);

    logic [3:0] cap_prev_reg;
    logic       ext_prev_reg;

    // ==========================================================
    // previous pin levels, pins are already synchronous
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_prev_reg <= 4'h0;
            ext_prev_reg <= 1'b0;
        end else begin
            cap_prev_reg <= eif.cap_pin;
            ext_prev_reg <= eif.ext_pin;
        end
    end

    // ==========================================================
    // per channel edge choice: 1 rising, 0 falling
    // selected capture edge
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (eif.edge_sel[i]) begin
                eif.cap_evt[i] = eif.cap_pin[i] & ~cap_prev_reg[i];
            end else begin
                eif.cap_evt[i] = ~eif.cap_pin[i] & cap_prev_reg[i];
            end
        end
    end

    assign eif.ext_rise = eif.ext_pin & ~ext_prev_reg;

endmodule // frt_edge_detect

// ---- hw/frt_timer.sv ----
// free running timer with compare, capture and ahb-lite registers
//
// How it works
// - match A sets status bit 3
// - match B sets status bit 2
// - counter wrap sets status bit 1
// - flag clears by read-one then write-zero
// - bit 0 clears counter on match A
// - per-input edge select, 1 rising
// - buffer A: register C backs A
// - buffer B: register D backs B
// - codes 00/01/10 pick div 2/8/32
// - code 11 counts external rising edges
// - buffered B capture shifts B into D
// - buffered A: input C flags, no store
//
// Chosen here: register access over AHB-Lite and the address map.
module frt_timer
    import frt_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        capture_in_a,
    input  wire logic        capture_in_b,
    input  wire logic        capture_in_c,
    input  wire logic        capture_in_d,
    input  wire logic        ext_count_clock_in,
    output logic             irq
);

    // ==========================================================
    // state
    logic [15:0] free_counter_reg;
    logic [15:0] free_counter_next;
    logic [15:0] compare_reg_a_reg;
    logic [15:0] compare_reg_b_reg;
    logic [15:0] capture_reg_a_reg;
    logic [15:0] capture_reg_b_reg;
    logic [15:0] capture_reg_c_reg;
    logic [15:0] capture_reg_d_reg;
    logic [7:0]  timer_control_reg;
    logic        clear_on_match_a_reg;
    logic [7:1]  flags_reg;
    logic [7:1]  flags_next;
    logic [7:1]  armed_reg;
    logic [7:1]  irq_stat_reg;
    logic [7:1]  irq_mask_reg;
    logic [4:0]  prescale_reg;
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic [31:0] hrdata_reg;

    // ==========================================================
    // decoded controls and events
    logic         edge_sel_cap_a;
    logic         edge_sel_cap_b;
    logic         edge_sel_cap_c;
    logic         edge_sel_cap_d;
    logic         buffer_pair_a;
    logic         buffer_pair_b;
    logic         clk_source_hi;
    logic         clk_source_lo;
    frt_clk_src_t clk_src;
    logic         count_tick;
    logic         match_a_hit;
    logic         match_b_hit;
    logic         wrap_hit;
    logic [7:1]   evt;
    logic [7:1]   flag_clr;
    logic         addr_phase;
    logic         rd_now;
    logic [7:0]   rd_addr;
    logic         wr_status;
    logic         wr_counter;

    frt_edge_if eif ();

    // ==========================================================
    // read mux, used only by the read data path
    function automatic logic [31:0] reg_read(input logic [7:0] a);
        logic [31:0] v;
        v = FRT_RD_ZERO;
        unique case (a)
            FRT_OFF_COUNTER:   v[15:0] = free_counter_reg;
            FRT_OFF_COMPARE_A: v[15:0] = compare_reg_a_reg;
            FRT_OFF_COMPARE_B: v[15:0] = compare_reg_b_reg;
            FRT_OFF_CAPTURE_A: v[15:0] = capture_reg_a_reg;
            FRT_OFF_CAPTURE_B: v[15:0] = capture_reg_b_reg;
            FRT_OFF_CAPTURE_C: v[15:0] = capture_reg_c_reg;
            FRT_OFF_CAPTURE_D: v[15:0] = capture_reg_d_reg;
            FRT_OFF_STATUS:    v[7:0]  = {flags_reg, clear_on_match_a_reg};
            FRT_OFF_CONTROL:   v[7:0]  = timer_control_reg;
            FRT_OFF_IRQ_MASK:  v[7:0]  = {irq_mask_reg, 1'b0};
            FRT_OFF_IRQ_STAT:  v[7:0]  = {irq_stat_reg, 1'b0};
            default:           v       = FRT_RD_ZERO;
        endcase
        return v;
    endfunction

    // prescaler tap test, true once per divided period
    function automatic logic div_hit(input logic [4:0] pre, input logic [4:0] mask);
        return (pre & mask) == mask;
    endfunction

    // ==========================================================
    // control field breakout
    assign edge_sel_cap_a = timer_control_reg[FRT_TC_EDGE_HI];
    assign edge_sel_cap_b = timer_control_reg[FRT_TC_EDGE_HI - 1];
    assign edge_sel_cap_c = timer_control_reg[FRT_TC_EDGE_LO + 1];
    assign edge_sel_cap_d = timer_control_reg[FRT_TC_EDGE_LO];
    assign buffer_pair_a  = timer_control_reg[FRT_TC_BUF_A];
    assign buffer_pair_b  = timer_control_reg[FRT_TC_BUF_B];
    assign clk_source_hi  = timer_control_reg[FRT_TC_CLK_HI];
    assign clk_source_lo  = timer_control_reg[FRT_TC_CLK_LO];
    assign clk_src        = frt_clk_src_t'({clk_source_hi, clk_source_lo});

    // ==========================================================
    // edge detection for capture pins and the external clock
    assign eif.cap_pin  = {capture_in_d, capture_in_c, capture_in_b, capture_in_a};
    assign eif.edge_sel = {edge_sel_cap_d, edge_sel_cap_c, edge_sel_cap_b, edge_sel_cap_a};
    assign eif.ext_pin  = ext_count_clock_in;

    frt_edge_detect u_edge (
        .hclk    (hclk),
        .hresetn (hresetn),
        .eif     (eif.detect)
    );

    // ==========================================================
    // ahb-lite slave: zero wait states, always okay
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_reg;
    assign addr_phase = hsel && htrans[1] && hready;
    assign rd_now     = addr_phase && !hwrite;
    assign rd_addr    = haddr[7:0];
    assign wr_status  = wr_pend_reg && (wr_addr_reg == FRT_OFF_STATUS);
    assign wr_counter = wr_pend_reg && (wr_addr_reg == FRT_OFF_COUNTER);

    // write address held into the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_reg <= haddr[7:0];
            end
        end
    end

    // read data taken at address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= FRT_RD_ZERO;
        end else if (rd_now) begin
            hrdata_reg <= reg_read(rd_addr);
        end
    end

    // ==========================================================
    // prescaler runs all the time so divided ticks stay periodic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale_reg <= FRT_PRE_RESET;
        end else begin
            prescale_reg <= prescale_reg + 5'h01;
        end
    end

    // count source selection
    always_comb begin
        unique case (clk_src)
            FRT_CLK_DIV2:  count_tick = div_hit(prescale_reg, FRT_DIV2_MASK);
            FRT_CLK_DIV8:  count_tick = div_hit(prescale_reg, FRT_DIV8_MASK);
            FRT_CLK_DIV32: count_tick = div_hit(prescale_reg, FRT_DIV32_MASK);
            FRT_CLK_EXT:   count_tick = eif.ext_rise;
        endcase
    end

    // ==========================================================
    // compare and wrap detection, taken on the counting tick so
    // a counter parked on a compare value flags only once
    // compare A equality
    assign match_a_hit = count_tick && (free_counter_reg == compare_reg_a_reg);
    assign match_b_hit = count_tick && (free_counter_reg == compare_reg_b_reg);
    assign wrap_hit    = count_tick && (free_counter_reg == FRT_CNT_MAX)
                         && !(match_a_hit && clear_on_match_a_reg);

    // counter next value, a software write wins over counting
    always_comb begin
        free_counter_next = free_counter_reg;
        if (wr_counter) begin
            free_counter_next = hwdata[15:0];
        end else if (count_tick) begin
            if (match_a_hit && clear_on_match_a_reg) begin
                free_counter_next = FRT_CNT_RESET;
            end else begin
                free_counter_next = free_counter_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            free_counter_reg <= FRT_CNT_RESET;
        end else begin
            free_counter_reg <= free_counter_next;
        end
    end

    // ==========================================================
    // compare registers, software writable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_reg_a_reg <= FRT_CMP_RESET;
            compare_reg_b_reg <= FRT_CMP_RESET;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == FRT_OFF_COMPARE_A) begin
                compare_reg_a_reg <= hwdata[15:0];
            end
            if (wr_addr_reg == FRT_OFF_COMPARE_B) begin
                compare_reg_b_reg <= hwdata[15:0];
            end
        end
    end

    // ==========================================================
    // capture registers A and C
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_reg_a_reg <= FRT_CNT_RESET;
            capture_reg_c_reg <= FRT_CNT_RESET;
        end else begin
            if (eif.cap_evt[0]) begin
                capture_reg_a_reg <= free_counter_reg;
            end
            if (buffer_pair_a) begin
                if (eif.cap_evt[0]) begin
                    capture_reg_c_reg <= capture_reg_a_reg;
                end
            end else if (eif.cap_evt[2]) begin
                capture_reg_c_reg <= free_counter_reg;
            end
        end
    end

    // capture registers B and D
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_reg_b_reg <= FRT_CNT_RESET;
            capture_reg_d_reg <= FRT_CNT_RESET;
        end else begin
            if (eif.cap_evt[1]) begin
                capture_reg_b_reg <= free_counter_reg;
            end
            if (buffer_pair_b) begin
                if (eif.cap_evt[1]) begin
                    capture_reg_d_reg <= capture_reg_b_reg;
                end
            end else if (eif.cap_evt[3]) begin
                capture_reg_d_reg <= free_counter_reg;
            end
        end
    end

    // ==========================================================
    // event vector in status layout; capture C and D still flag
    // in buffered mode, usable as plain external interrupts
    // C flags without store
    assign evt = {eif.cap_evt[0], eif.cap_evt[1], eif.cap_evt[2], eif.cap_evt[3],
                  match_a_hit, match_b_hit, wrap_hit};

    assign flag_clr = wr_status ? (~hwdata[7:1] & armed_reg) : 7'h00;

    // set wins over a clear in the same cycle
    assign flags_next = (flags_reg & ~flag_clr) | evt;

    // ==========================================================
    // status flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_reg <= FRT_FLAG_RESET[7:1];
        end else begin
            flags_reg <= flags_next;
        end
    end

    // arming: a flag seen as one by a status read may be cleared
    // by the next status write; any status write disarms, so a
    // stale read cannot clear a later event
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_reg <= FRT_FLAG_RESET[7:1];
        end else begin
            armed_reg <= (wr_status ? 7'h00 : armed_reg)
                         | ((rd_now && rd_addr == FRT_OFF_STATUS) ? flags_reg : 7'h00);
        end
    end

    // ==========================================================
    // control bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_control_reg    <= FRT_CTRL_RESET;
            clear_on_match_a_reg <= FRT_CTRL_RESET[FRT_ST_CLR_A];
        end else begin
            if (wr_pend_reg && wr_addr_reg == FRT_OFF_CONTROL) begin
                timer_control_reg <= hwdata[7:0];
            end
            if (wr_status) begin
                clear_on_match_a_reg <= hwdata[FRT_ST_CLR_A];
            end
        end
    end

    // ==========================================================
    // interrupt status (write one to clear) and mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= FRT_FLAG_RESET[7:1];
            irq_mask_reg <= FRT_FLAG_RESET[7:1];
        end else begin
            if (wr_pend_reg && wr_addr_reg == FRT_OFF_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~hwdata[7:1]) | evt;
            end else begin
                irq_stat_reg <= irq_stat_reg | evt;
            end
            if (wr_pend_reg && wr_addr_reg == FRT_OFF_IRQ_MASK) begin
                irq_mask_reg <= hwdata[7:1];
            end
        end
    end

    // level interrupt, high while any unmasked event is pending
    assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule // frt_timer

// ---- tb/frt_checker.sv ----
// timer bus and interrupt assertions
module frt_checker
    import frt_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        irq
);
    logic        wr_pend, rd_chk, clr_sh;
    logic [7:0]  wr_addr, rd_addr, ctrl_sh, irqm_sh;
    logic [15:0] cmpa_sh, cmpb_sh;
    wire         take = hsel && htrans[1] && hready;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // bus phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_chk  <= 1'b0;
            wr_addr <= 8'h00;
            rd_addr <= 8'h00;
        end else begin
            wr_pend <= take && hwrite;
            rd_chk  <= take && !hwrite;
            wr_addr <= haddr[7:0];
            rd_addr <= haddr[7:0];
        end
    end

    // shadow copies, written in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_sh <= FRT_CTRL_RESET;
            irqm_sh <= 8'h00;
            cmpa_sh <= FRT_CMP_RESET;
            cmpb_sh <= FRT_CMP_RESET;
            clr_sh  <= 1'b0;
        end else if (wr_pend) begin
            case (wr_addr)
                FRT_OFF_CONTROL:   ctrl_sh <= hwdata[7:0];
                FRT_OFF_IRQ_MASK:  irqm_sh <= hwdata[7:0];
                FRT_OFF_COMPARE_A: cmpa_sh <= hwdata[15:0];
                FRT_OFF_COMPARE_B: cmpb_sh <= hwdata[15:0];
                FRT_OFF_STATUS:    clr_sh  <= hwdata[0];
                default:           ;
            endcase
        end
    end

    // ==========================================================
    // assertions
    a_ready_always: assert property (take |=> hreadyout && !hresp)
        else $error("bus stall or error");
    a_rdata_holds: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data changed");
    a_ctrl_read_back: assert property (
        rd_chk && rd_addr == FRT_OFF_CONTROL |-> hrdata == {24'h00_0000, $past(ctrl_sh)})
        else $error("control readback");
    a_cmpa_read_back: assert property (
        rd_chk && rd_addr == FRT_OFF_COMPARE_A |-> hrdata == {16'h0000, $past(cmpa_sh)})
        else $error("compare a readback");
    a_cmpb_read_back: assert property (
        rd_chk && rd_addr == FRT_OFF_COMPARE_B |-> hrdata == {16'h0000, $past(cmpb_sh)})
        else $error("compare b readback");
    a_clr_bit_kept: assert property (
        rd_chk && rd_addr == FRT_OFF_STATUS |-> hrdata[0] == $past(clr_sh) && hrdata[31:8] == 24'h00_0000)
        else $error("status bit 0 wrong");
    a_capture_upper_zero: assert property (
        rd_chk && rd_addr inside {[FRT_OFF_CAPTURE_A:FRT_OFF_CAPTURE_D]} |-> hrdata[31:16] == 16'h0000)
        else $error("capture upper bits");
    a_unmapped_zero: assert property (rd_chk && rd_addr > FRT_OFF_IRQ_STAT |-> hrdata == FRT_RD_ZERO)
        else $error("unmapped read");
    a_irq_needs_mask: assert property (irq |-> irqm_sh[7:1] != 7'h00)
        else $error("irq with all masked");

    // main scenarios reached
    c_match_seen: cover property (rd_chk && rd_addr == FRT_OFF_STATUS && hrdata[3]);
    c_irq_seen: cover property ($rose(irq));
    c_unmapped_seen: cover property (rd_chk && rd_addr > FRT_OFF_IRQ_STAT);
endmodule // frt_checker

bind frt_timer frt_checker u_frt_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq));

// ---- tb/tb_top.sv ----
// self-checking bench for the timer
module tb_top
    import frt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, ext_pin;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  cap, sel;
    logic [15:0] e;
    logic [7:0]  v;
    int          n_fail, check_count;

    frt_timer DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .capture_in_a(cap[0]), .capture_in_b(cap[1]), .capture_in_c(cap[2]),
        .capture_in_d(cap[3]), .ext_count_clock_in(ext_pin), .irq(irq)
    );
    // one slave drives hready
    assign hready = hreadyout;

    // ==========================================================
    // clock, watchdog, helpers
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // whole run needs about 1300 cycles
    initial begin
        #(200_000);
        n_fail++;
        complete_run();
    end

    task automatic complete_run();
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // single word: address phase, then data phase
    task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        q = hrdata;
    endtask

    task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
        ahb_xfer(1'b1, a, d, rd);
    endtask

    task automatic ahb_rd(input logic [7:0] a);
        ahb_xfer(1'b0, a, 32'h0000_0000, rd);
    endtask

    // pins change, then settle
    task automatic set_pins(input logic [3:0] p);
        cap <= p;
        repeat (4) @(posedge hclk);
    endtask

    // e4: expected a, b, c, d, top down
    task automatic check_caps(input logic [63:0] e4);
        for (int i = 0; i < 4; i++) begin
            ahb_rd(FRT_OFF_CAPTURE_A + 8'(4 * i));
            check("capture register", rd, {16'h0000, e4[63 - 16 * i -: 16]});
        end
    endtask

    // expected ticks over cyc clocks
    function automatic logic [15:0] ticks(input int cyc, input int code);
        return 16'(cyc >> (code * 2 + 1));
    endfunction

    // ==========================================================
    // main sequence
    initial begin
        {hresetn, hsel, hwrite, ext_pin, haddr, hwdata, htrans, cap} = '0;
        hsize = 3'b010;
        n_fail = 0;
        check_count = 0;
        void'($urandom(14));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb_rd(FRT_OFF_CONTROL);
        check("control reset", rd, 32'h0000_0000);
        ahb_rd(FRT_OFF_STATUS);
        check("status reset", rd, 32'h0000_0000);
        // random controls, then unmapped
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom());
            ahb_wr(FRT_OFF_CONTROL, {24'h00_0000, v});
            ahb_rd(FRT_OFF_CONTROL);
            check("control", rd, {24'h00_0000, v});
        end
        ahb_rd(8'h3C);
        check("unmapped", rd, 32'h0000_0000);
        // free prescaler: allow one tick either way
        for (int c = 0; c < 3; c++) begin
            ahb_wr(FRT_OFF_CONTROL, 32'(c));
            ahb_wr(FRT_OFF_COUNTER, 32'h0000_0000);
            repeat (320) @(posedge hclk);
            ahb_rd(FRT_OFF_COUNTER);
            e = ticks(320, c);
            check("prescaled count", {31'h0, rd[15:0] >= e - 1 && rd[15:0] <= e + 1}, 32'h0000_0001);
        end
        ahb_wr(FRT_OFF_CONTROL, 32'h0000_0003);
        ahb_wr(FRT_OFF_COUNTER, 32'h0000_0000);
        repeat (5) begin
            ext_pin <= 1'b1;
            repeat (2) @(posedge hclk);
            ext_pin <= 1'b0;
            repeat (2) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
        ahb_rd(FRT_OFF_COUNTER);
        check("external count", rd, 32'h0000_0005);
        // matches; writing ones only disarms
        ahb_wr(FRT_OFF_CONTROL, 32'h0000_0000);
        ahb_wr(FRT_OFF_COMPARE_A, 32'h0000_0005);
        ahb_wr(FRT_OFF_COMPARE_B, 32'h0000_0007);
        ahb_wr(FRT_OFF_COUNTER, 32'h0000_0000);
        repeat (40) @(posedge hclk);
        ahb_rd(FRT_OFF_STATUS);
        check("match flags", rd & 32'h0000_000E, 32'h0000_000C);
        ahb_wr(FRT_OFF_STATUS, 32'h0000_000E);
        ahb_wr(FRT_OFF_STATUS, 32'h0000_0000);
        ahb_rd(FRT_OFF_STATUS);
        check("flags kept", rd & 32'h0000_000C, 32'h0000_000C);
        ahb_wr(FRT_OFF_STATUS, 32'h0000_0000);
        ahb_rd(FRT_OFF_STATUS);
        check("flags cleared", rd & 32'h0000_000C, 32'h0000_0000);
        // wrap, then interrupt raised, masked and cleared
        ahb_wr(FRT_OFF_COUNTER, 32'h0000_FFF8);
        repeat (40) @(posedge hclk);
        ahb_rd(FRT_OFF_STATUS);
        check("wrap flag", rd & 32'h0000_0002, 32'h0000_0002);
        ahb_wr(FRT_OFF_IRQ_MASK, 32'h0000_0002);
        #1 check("irq raised", {31'h0, irq}, 32'h0000_0001);
        ahb_wr(FRT_OFF_IRQ_MASK, 32'h0000_0000);
        #1 check("irq masked", {31'h0, irq}, 32'h0000_0000);
        ahb_wr(FRT_OFF_IRQ_MASK, 32'h0000_0002);
        ahb_wr(FRT_OFF_IRQ_STAT, 32'h0000_0002);
        #1 check("irq cleared", {31'h0, irq}, 32'h0000_0000);
        // clear on match a bounds the counter
        ahb_wr(FRT_OFF_COMPARE_A, 32'h0000_0003);
        ahb_wr(FRT_OFF_STATUS, 32'h0000_0001);
        ahb_wr(FRT_OFF_COUNTER, 32'h0000_0000);
        repeat (10) begin
            ahb_rd(FRT_OFF_COUNTER);
            check("cleared counter", {31'h0, rd <= 32'h0000_0003}, 32'h0000_0001);
        end
        ahb_wr(FRT_OFF_STATUS, 32'h0000_0000);
        // counter frozen in external mode
        sel = 4'($urandom());
        set_pins(sel);
        ahb_wr(FRT_OFF_CONTROL, {24'h00_0000, sel[0], sel[1], sel[2], sel[3], 4'h3});
        ahb_wr(FRT_OFF_COUNTER, 32'h0000_1234);
        set_pins(~sel);
        check_caps(64'h0000_0000_0000_0000);
        set_pins(sel);
        check_caps(64'h1234_1234_1234_1234);
        // buffered: second capture pushes first into c, d
        ahb_wr(FRT_OFF_CONTROL, {24'h00_0000, sel[0], sel[1], sel[2], sel[3], 4'hF});
        ahb_wr(FRT_OFF_COUNTER, 32'h0000_2222);
        set_pins(sel ^ 4'h3);
        set_pins(sel);
        ahb_wr(FRT_OFF_COUNTER, 32'h0000_3333);
        set_pins(sel ^ 4'h3);
        set_pins(sel);
        check_caps(64'h3333_3333_2222_2222);
        ahb_rd(FRT_OFF_STATUS);
        ahb_wr(FRT_OFF_STATUS, 32'h0000_0000);
        set_pins(sel ^ 4'hC);
        set_pins(sel);
        check_caps(64'h3333_3333_2222_2222);
        ahb_rd(FRT_OFF_STATUS);
        check("c d flags", rd & 32'h0000_0030, 32'h0000_0030);
        complete_run();
    end
endmodule // tb_top
